// ===== shared/sms_pkg.sv
// Constants shared by the sensor monitor sequencer design files.
package sms_pkg;

    // ----------------------------------------------------------------
    // Register port geometry and offsets
    // ----------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    localparam logic [15:0] OFF_ANALOG_GAIN   = 16'h0467;
    localparam logic [15:0] OFF_BYPASS_READ   = 16'h0468;
    localparam logic [15:0] OFF_SEQ_CTRL      = 16'h046A;
    localparam logic [15:0] OFF_READOUT_VALUE = 16'h047B;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [15:0] RST_ANALOG_GAIN = 16'h0012;
    localparam logic [15:0] RST_BYPASS_READ = 16'h0920;
    localparam logic [15:0] RST_SEQ_CTRL    = 16'h0094;
    localparam logic [15:0] SEQ_CTRL_MASK   = 16'h01FF;

    // ----------------------------------------------------------------
    // Field positions of the sequencer control register
    // ----------------------------------------------------------------
    localparam int SEQ_START    = 0;
    localparam int SEQ_PERIODIC = 1;
    localparam int SEQ_HOLD     = 2;
    localparam int SEQ_FORCE    = 3;
    localparam int SEQ_DIV_LO   = 4;
    localparam int SEQ_AVG      = 6;
    localparam int SEQ_DISCARD  = 7;
    localparam int SEQ_HCLR     = 8;

    // ----------------------------------------------------------------
    // Field positions of the bypass and readout register
    // ----------------------------------------------------------------
    localparam int BYP_SEL_LO      = 0;
    localparam int BYP_OFFCAL_LO   = 3;
    localparam int BYP_GAINCAL_LO  = 6;
    localparam int BYP_SENSDEC_LO  = 9;
    localparam int BYP_RDSEL_LO    = 12;
    localparam int BYP_MANHOLD     = 15;

    // ----------------------------------------------------------------
    // Field positions of the analog gain register
    // ----------------------------------------------------------------
    localparam int GAIN_FIRST_LO  = 0;
    localparam int GAIN_SECOND_LO = 3;
    localparam int GAIN_ARITH_LO  = 6;
    localparam int GAIN_DC_LO     = 8;

    // ----------------------------------------------------------------
    // Monitor ADC clock and sample counts
    // ----------------------------------------------------------------
    localparam int CLK_HZ      = 200_000_000;
    localparam int ADC_HZ_FAST = 12_500_000;
    localparam int ADC_HZ_MID  = 6_250_000;
    localparam int ADC_HZ_SLOW = 3_125_000;
    localparam logic [5:0] ADC_HALF_FAST = 6'(CLK_HZ / (2 * ADC_HZ_FAST));
    localparam logic [5:0] ADC_HALF_MID  = 6'(CLK_HZ / (2 * ADC_HZ_MID));
    localparam logic [5:0] ADC_HALF_SLOW = 6'(CLK_HZ / (2 * ADC_HZ_SLOW));
    localparam logic [1:0] ADC_DIV_FAST  = 2'h0;
    localparam logic [1:0] ADC_DIV_MID   = 2'h1;

    localparam logic [1:0] SAMPLES_LAST_TWO  = 2'h1;
    localparam logic [1:0] SAMPLES_LAST_FOUR = 2'h3;

    localparam int HIST_AW = 3;
    localparam logic [HIST_AW-1:0] SENSOR_LAST = 3'h7;
    localparam int ACC_W = 18;

    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SMS_IDLE    = 4'b0001,
        SMS_DISCARD = 4'b0010,
        SMS_ACCUM   = 4'b0100,
        SMS_STORE   = 4'b1000
    } sms_state_e;

endpackage

// ===== rtl/sms_hist_mem.sv
// History store of averaged sensor results, one word per sensor.
`timescale 1ns/10ps
module sms_hist_mem (
    // Clock
    input  wire logic                        clk_sys_i,
    // Write port
    input  wire logic                        wr_en_i,
    input  wire logic [sms_pkg::HIST_AW-1:0] wr_addr_i,
    input  wire logic [sms_pkg::DATA_W-1:0]  wr_data_i,
    // Read port
    input  wire logic [sms_pkg::HIST_AW-1:0] rd_addr_i,
    output logic      [sms_pkg::DATA_W-1:0]  rd_data_o
);
    import sms_pkg::*;

    logic [DATA_W-1:0] mem_reg [0:(1<<HIST_AW)-1];

    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
    end

    // Contents are zeroed by the owner after reset, so no reset here.
    always_ff @(posedge clk_sys_i) begin
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule

// ===== rtl/sms_sensor_monitor.sv
// Sensor monitor sequencer with its management registers.
// Behaviour
// (RQ1) Hold bit keeps monitor in reset; resets set.
// (RQ2) Setting hold abandons any sequence at once.
// (RQ3) Writing start launches; hardware clears start itself.
// (RQ4) Periodic clear: one pass; set: repeat passes.
// (RQ5) Start waits for link unless forced.
// (RQ6) Discard two or four samples before averaging.
// (RQ7) Average two or four samples into history.
// (RQ8) Divider field picks 12.5, 6.25, 3.125 MHz.
// (RQ9) Bypass: manual field selects the converted sensor.
// (RQ10) Bypass: manual hold bit drives sensor reset.
// (RQ11) Readout select shows one result in readout register.
// (RQ12) History clear bit zeroes every stored result.
// (RQ13) Analog trim fields pass unchanged to front end.
`timescale 1ns/10ps
module sms_sensor_monitor (
    // Clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       rst_n_i,
    // Management register port
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    input  wire logic [sms_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [sms_pkg::DATA_W-1:0] reg_wdata_i,
    output logic      [sms_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                            reg_rvalid_o,
    // System status and mode
    input  wire logic                       link_up_i,
    input  wire logic                       seq_bypass_i,
    // Monitor ADC and sensors
    input  wire logic [sms_pkg::DATA_W-1:0] adc_data_i,
    output logic                            adc_clk_o,
    output logic                            mon_rst_o,
    output logic [sms_pkg::HIST_AW-1:0]     sensor_sel_o,
    output logic                            sensor_rst_o,
    // Analog front end configuration
    output logic [7:0]                      dc_offset_trim_o,
    output logic [1:0]                      combined_gain_arith_o,
    output logic [2:0]                      second_stage_gain_o,
    output logic [2:0]                      first_stage_gain_o,
    output logic [2:0]                      sensor_decimation_o,
    output logic [2:0]                      gain_cal_decimation_o,
    output logic [2:0]                      offset_cal_decimation_o
);
    import sms_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]  gain_reg;
    logic [DATA_W-1:0]  byp_reg;
    logic [DATA_W-1:0]  seq_reg;
    logic [DATA_W-1:0]  seq_next;
    logic               link_meta_reg;
    logic               link_sync_reg;
    logic [DATA_W-1:0]  adc_meta_reg;
    logic [DATA_W-1:0]  adc_sync_reg;
    logic [5:0]         div_cnt_reg;
    logic [5:0]         half_period;
    logic               adc_clk_reg;
    logic               toggle;
    logic               tick;
    sms_state_e         state_reg;
    logic [1:0]         cnt_reg;
    logic [HIST_AW-1:0] idx_reg;
    logic [ACC_W-1:0]   acc_reg;
    logic [ACC_W-1:0]   acc_next;
    logic               clr_busy_reg;
    logic [HIST_AW-1:0] clr_idx_reg;
    logic               hold;
    logic               bypass;
    logic               gate;
    logic               launch;
    logic               store_go;
    logic [1:0]         disc_last;
    logic [1:0]         avg_last;
    logic [DATA_W-1:0]  avg_val;
    logic               mem_we;
    logic [HIST_AW-1:0] mem_waddr;
    logic [DATA_W-1:0]  mem_wdata;
    logic [DATA_W-1:0]  mem_rdata;
    logic               wr_gain;
    logic               wr_byp;
    logic               wr_seq;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] off);
        addr_hit = (addr == off);
    endfunction

    // ----------------------------------------------------------------
    // Synchronisers for inputs from outside the clock domain
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            link_meta_reg <= 1'b0;
            link_sync_reg <= 1'b0;
            adc_meta_reg  <= '0;
            adc_sync_reg  <= '0;
        end else begin
            link_meta_reg <= link_up_i;
            link_sync_reg <= link_meta_reg;
            adc_meta_reg  <= adc_data_i;
            adc_sync_reg  <= adc_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    assign wr_gain = reg_wr_i && addr_hit(reg_addr_i, OFF_ANALOG_GAIN);
    assign wr_byp  = reg_wr_i && addr_hit(reg_addr_i, OFF_BYPASS_READ);
    assign wr_seq  = reg_wr_i && addr_hit(reg_addr_i, OFF_SEQ_CTRL);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            gain_reg <= RST_ANALOG_GAIN;
            byp_reg  <= RST_BYPASS_READ;
        end else begin
            if (wr_gain) begin
                gain_reg <= reg_wdata_i; // RQ13
            end
            if (wr_byp) begin
                byp_reg <= reg_wdata_i;
            end
        end
    end

    // A write of one to start beats the clear from an accepted launch,
    // so a request arriving in the launch cycle is kept.
    always_comb begin
        seq_next = seq_reg;
        if (launch || seq_reg[SEQ_HOLD]) begin
            seq_next[SEQ_START] = 1'b0; // RQ3
        end
        if (wr_seq) begin
            seq_next = reg_wdata_i & SEQ_CTRL_MASK;
            seq_next[SEQ_START] = reg_wdata_i[SEQ_START] |
                                  (seq_reg[SEQ_START] & ~launch); // RQ3
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            seq_reg <= RST_SEQ_CTRL; // RQ1
        end else begin
            seq_reg <= seq_next;
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                if (addr_hit(reg_addr_i, OFF_ANALOG_GAIN)) begin
                    reg_rdata_o <= gain_reg;
                end else if (addr_hit(reg_addr_i, OFF_BYPASS_READ)) begin
                    reg_rdata_o <= byp_reg;
                end else if (addr_hit(reg_addr_i, OFF_SEQ_CTRL)) begin
                    reg_rdata_o <= seq_reg;
                end else if (addr_hit(reg_addr_i, OFF_READOUT_VALUE)) begin
                    reg_rdata_o <= mem_rdata; // RQ11
                end else begin
                    reg_rdata_o <= '0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Monitor ADC clock divider
    // ----------------------------------------------------------------
    // The reserved divider code runs at the slowest rate, the safe side
    // for an ADC that may not tolerate an undefined clock.
    always_comb begin
        case (seq_reg[SEQ_DIV_LO +: 2])
            ADC_DIV_FAST: half_period = ADC_HALF_FAST; // RQ8
            ADC_DIV_MID:  half_period = ADC_HALF_MID;  // RQ8
            default:      half_period = ADC_HALF_SLOW; // RQ8
        endcase
    end

    assign toggle = (div_cnt_reg >= half_period - 6'h01);
    assign tick   = toggle && !adc_clk_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            div_cnt_reg <= '0;
            adc_clk_reg <= 1'b0;
        end else if (toggle) begin
            div_cnt_reg <= '0;
            adc_clk_reg <= ~adc_clk_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    assign hold      = seq_reg[SEQ_HOLD];
    assign bypass    = seq_bypass_i;
    assign gate      = link_sync_reg || seq_reg[SEQ_FORCE]; // RQ5
    assign launch    = (state_reg == SMS_IDLE) && seq_reg[SEQ_START] &&
                       gate && !hold && !bypass;
    assign disc_last = seq_reg[SEQ_DISCARD] ? SAMPLES_LAST_FOUR
                                            : SAMPLES_LAST_TWO; // RQ6
    assign avg_last  = seq_reg[SEQ_AVG] ? SAMPLES_LAST_FOUR
                                        : SAMPLES_LAST_TWO; // RQ7
    assign acc_next  = acc_reg + {{(ACC_W-DATA_W){1'b0}}, adc_sync_reg};
    assign avg_val   = seq_reg[SEQ_AVG] ? acc_reg[ACC_W-1:2]
                                        : acc_reg[DATA_W:1]; // RQ7
    assign store_go  = (state_reg == SMS_STORE) && !clr_busy_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_reg <= SMS_IDLE;
            cnt_reg   <= '0;
            idx_reg   <= '0;
            acc_reg   <= '0;
        end else if (hold || bypass) begin
            state_reg <= SMS_IDLE; // RQ1 RQ2
            cnt_reg   <= '0;
            idx_reg   <= '0;
            acc_reg   <= '0;
        end else begin
            case (state_reg)
                SMS_IDLE: begin
                    if (launch) begin
                        state_reg <= SMS_DISCARD; // RQ3 RQ5
                        cnt_reg   <= '0;
                        idx_reg   <= '0;
                    end
                end
                SMS_DISCARD: begin
                    if (tick) begin
                        if (cnt_reg == disc_last) begin
                            state_reg <= SMS_ACCUM; // RQ6
                            cnt_reg   <= '0;
                            acc_reg   <= '0;
                        end else begin
                            cnt_reg <= cnt_reg + 2'h1;
                        end
                    end
                end
                SMS_ACCUM: begin
                    if (tick) begin
                        acc_reg <= acc_next;
                        if (cnt_reg == avg_last) begin
                            state_reg <= SMS_STORE; // RQ7
                        end else begin
                            cnt_reg <= cnt_reg + 2'h1;
                        end
                    end
                end
                SMS_STORE: begin
                    if (store_go) begin
                        cnt_reg <= '0;
                        if (idx_reg != SENSOR_LAST) begin
                            idx_reg   <= idx_reg + 3'h1;
                            state_reg <= SMS_DISCARD;
                        end else if (seq_reg[SEQ_PERIODIC] && gate) begin
                            idx_reg   <= '0;
                            state_reg <= SMS_DISCARD; // RQ4
                        end else begin
                            state_reg <= SMS_IDLE; // RQ4
                        end
                    end
                end
                default: begin
                    state_reg <= SMS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // History clear walker
    // ----------------------------------------------------------------
    // The walker also runs after reset so the store never reads stale
    // contents; a result waiting to be stored is held until it ends.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            clr_busy_reg <= 1'b1;
            clr_idx_reg  <= '0;
        end else if (wr_seq && reg_wdata_i[SEQ_HCLR]) begin
            clr_busy_reg <= 1'b1; // RQ12
            clr_idx_reg  <= '0;
        end else if (clr_busy_reg) begin
            clr_idx_reg <= clr_idx_reg + 3'h1;
            if (clr_idx_reg == SENSOR_LAST) begin
                clr_busy_reg <= 1'b0;
            end
        end
    end

    assign mem_we    = clr_busy_reg || (store_go && !hold && !bypass);
    assign mem_waddr = clr_busy_reg ? clr_idx_reg : idx_reg;
    assign mem_wdata = clr_busy_reg ? '0 : avg_val; // RQ12

    sms_hist_mem u_hist (
        .clk_sys_i (clk_sys_i),
        .wr_en_i   (mem_we),
        .wr_addr_i (mem_waddr),
        .wr_data_i (mem_wdata),
        .rd_addr_i (byp_reg[BYP_RDSEL_LO +: HIST_AW]), // RQ11
        .rd_data_o (mem_rdata)
    );

    // ----------------------------------------------------------------
    // Outputs to the analog side
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            adc_clk_o    <= 1'b0;
            mon_rst_o    <= 1'b1;
            sensor_sel_o <= '0;
            sensor_rst_o <= 1'b1;
        end else begin
            adc_clk_o <= adc_clk_reg;
            mon_rst_o <= seq_next[SEQ_HOLD]; // RQ1
            if (bypass) begin
                sensor_sel_o <= byp_reg[BYP_SEL_LO +: HIST_AW]; // RQ9
                sensor_rst_o <= byp_reg[BYP_MANHOLD]; // RQ10
            end else begin
                sensor_sel_o <= idx_reg;
                sensor_rst_o <= hold || (state_reg == SMS_IDLE);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            {dc_offset_trim_o, combined_gain_arith_o, second_stage_gain_o,
             first_stage_gain_o} <= RST_ANALOG_GAIN;
            {sensor_decimation_o, gain_cal_decimation_o,
             offset_cal_decimation_o} <= RST_BYPASS_READ[BYP_OFFCAL_LO +: 9];
        end else begin
            {dc_offset_trim_o, combined_gain_arith_o, second_stage_gain_o,
             first_stage_gain_o} <= gain_reg; // RQ13
            {sensor_decimation_o, gain_cal_decimation_o,
             offset_cal_decimation_o} <= byp_reg[BYP_OFFCAL_LO +: 9]; // RQ13
        end
    end
endmodule

// ===== bench/sms_properties.sv
// Port checker for the sensor monitor sequencer.
`timescale 1ns/10ps
module sms_properties
    import sms_pkg::*;
(
    // Clock, reset and register port
    input wire logic                clk_sys_i,
    input wire logic                rst_n_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input wire logic [ADDR_W-1:0]   reg_addr_i,
    input wire logic [DATA_W-1:0]   reg_wdata_i,
    input wire logic [DATA_W-1:0]   reg_rdata_o,
    input wire logic                reg_rvalid_o,
    // Monitor side
    input wire logic                seq_bypass_i,
    input wire logic                adc_clk_o,
    input wire logic                mon_rst_o,
    input wire logic [HIST_AW-1:0]  sensor_sel_o,
    input wire logic                sensor_rst_o,
    input wire logic [7:0]          dc_offset_trim_o
);
    logic [15:0] byp_q;
    logic [1:0]  div_q;
    logic [5:0]  run_q;
    logic [5:0]  half;
    logic        lvl_q;
    logic        seen_q;
    wire wr_ctl = reg_wr_i && reg_addr_i == OFF_SEQ_CTRL;
    wire wr_gain = reg_wr_i && reg_addr_i == OFF_ANALOG_GAIN;

    assign half = div_q == 2'h0 ? ADC_HALF_FAST :
                  div_q == 2'h1 ? ADC_HALF_MID : ADC_HALF_SLOW;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            byp_q <= RST_BYPASS_READ;
            div_q <= 2'h1;
        end else begin
            if (reg_wr_i && reg_addr_i == OFF_BYPASS_READ) byp_q <= reg_wdata_i;
            if (wr_ctl) div_q <= reg_wdata_i[5:4];
        end
    end
    // A divider write restarts the count; skip the first toggle.
    always_ff @(posedge clk_sys_i) begin
        lvl_q <= adc_clk_o;
        if (!rst_n_i || wr_ctl || seq_bypass_i) begin
            run_q <= 6'h00;
            seen_q <= 1'b0;
        end else if (adc_clk_o != lvl_q) begin
            run_q <= 6'h00;
            seen_q <= 1'b1;
        end else if (run_q != 6'h3F) run_q <= run_q + 6'h01;
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_hold_wr;
        wr_ctl && reg_wdata_i[SEQ_HOLD];
    endsequence
    sequence s_held;
        (mon_rst_o && !seq_bypass_i)[*3];
    endsequence
    property p_rd_ans;
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_ctl_resv;
        reg_rd_i && reg_addr_i == OFF_SEQ_CTRL |=> reg_rdata_o[15:9] == 7'h00;
    endproperty
    a_ctl_resv: assert property (p_ctl_resv) else $error("reserved set");
    property p_hold_mon;
        s_hold_wr |=> mon_rst_o;
    endproperty
    a_hold_mon: assert property (p_hold_mon) else $error("hold late");
    property p_hold_abort;
        s_hold_wr ##0 !seq_bypass_i |-> ##[1:3] sensor_rst_o;
    endproperty
    a_hold_abort: assert property (p_hold_abort) else $error("no abort");
    property p_held;
        s_held |-> sensor_rst_o;
    endproperty
    a_held: assert property (p_held) else $error("sensor runs held");
    property p_byp;
        (seq_bypass_i && $stable(byp_q))[*3]
            |-> sensor_sel_o == byp_q[2:0] && sensor_rst_o == byp_q[15];
    endproperty
    a_byp: assert property (p_byp) else $error("bypass ignored");
    property p_trim;
        wr_gain |=> ##1 dc_offset_trim_o == $past(reg_wdata_i[15:8], 2);
    endproperty
    a_trim: assert property (p_trim) else $error("trim not copied");
    property p_adc_half;
        seen_q && adc_clk_o != lvl_q |-> run_q == half - 6'h01;
    endproperty
    a_adc_half: assert property (p_adc_half) else $error("adc rate");
endmodule

bind sms_sensor_monitor sms_properties sms_properties_i (.*);

// ===== bench/sms_adc_model.sv
// Behavioural monitor ADC: sample j of sensor s reads 0x0100+s*0x1000+4*j.
`timescale 1ns/10ps
module sms_adc_model (
    // Clock and monitor controls
    input  wire logic        clk_sys_i,
    input  wire logic        adc_clk_i,
    input  wire logic [2:0]  sel_i,
    input  wire logic        sens_rst_i,
    // Sample
    output logic      [15:0] data_o
);
    logic [15:0] dat_q = 16'hA5A5;
    logic [15:0] idx_q = 16'h0001;
    logic [2:0]  sel_q = 3'h0;
    logic        adc_q = 1'b0;
    logic        rst_q = 1'b1;
    wire  [15:0] base = 16'h0100 + {1'b0, sel_i, 12'h000};
    assign data_o = dat_q;
    // A sensor in reset gives a toggling pattern, never a usable value.
    always @(posedge clk_sys_i) begin
        adc_q <= adc_clk_i;
        sel_q <= sel_i;
        rst_q <= sens_rst_i;
        if (sens_rst_i) begin
            dat_q <= ~dat_q;
            idx_q <= 16'h0001;
        end else if (rst_q || sel_i != sel_q) begin
            dat_q <= base;
            idx_q <= 16'h0001;
        end else if (!adc_q && adc_clk_i) begin
            dat_q <= base + (idx_q << 2);
            idx_q <= idx_q + 16'h0001;
        end
    end
endmodule

// ===== bench/test_sms_sensor_monitor.sv
// Self-checking testbench of the sensor monitor sequencer.
`timescale 1ns/10ps
module test_sms_sensor_monitor;
    import sms_pkg::*;
    logic clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, link_up_i;
    logic seq_bypass_i, adc_clk_o, mon_rst_o, sensor_rst_o;
    logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, adc_data_i, v;
    logic [2:0] sensor_sel_o, second_stage_gain_o, first_stage_gain_o;
    logic [2:0] sensor_decimation_o, gain_cal_decimation_o,
        offset_cal_decimation_o;
    logic [7:0] dc_offset_trim_o;
    logic [1:0] combined_gain_arith_o, dv;
    int err_total, compares, seed, k;

    sms_sensor_monitor sms_sensor_monitor_i (.*);
    sms_adc_model sms_adc_model_i (.clk_sys_i, .adc_clk_i(adc_clk_o),
        .sel_i(sensor_sel_o), .sens_rst_i(sensor_rst_o), .data_o(adc_data_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #500000;
        err_total++;
        print_verdict;
    end

    function logic [15:0] avg_exp(int s, d, a);
        return 16'h010A + 16'(s) * 16'h1000 + 16'(8 * d + 4 * a);
    endfunction
    task chk(input logic [15:0] g, e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task wr(input logic [15:0] a, d);
        cyc(1);
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, a, d};
        cyc(1);
        reg_wr_i = 1'b0;
    endtask
    task rdc(input logic [15:0] a, e);
        cyc(1);
        {reg_rd_i, reg_addr_i} = {1'b1, a};
        cyc(1);
        reg_rd_i = 1'b0;
        chk(reg_rdata_o, e);
    endtask
    task wt(input bit on_sel, input logic [2:0] val);
        int n;
        for (n = 0; n < 20000; n++) begin
            if (on_sel ? sensor_sel_o === val : sensor_rst_o === val[0]) break;
            cyc(1);
        end
        chk(16'(n), 16'(n < 20000 ? n : 0));
    endtask
    task hist(input int d, a, input bit z);
        for (int s = 0; s < 8; s++) begin
            wr(OFF_BYPASS_READ, 16'(s) << 12);
            cyc(2);
            rdc(OFF_READOUT_VALUE, z ? 16'h0000 : avg_exp(s, d, a));
        end
    endtask
    task finish_pass(input logic [15:0] c, input int d, a);
        wt(0, 3'h0);
        wt(1, 3'h7);
        wt(0, 3'h1);
        rdc(OFF_SEQ_CTRL, c);
        hist(d, a, 0);
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        seed = 15055;
        {rst_n_i, reg_wr_i, reg_rd_i, link_up_i, seq_bypass_i} = 5'h00;
        {reg_addr_i, reg_wdata_i} = 32'h0;
        repeat (12) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        rdc(OFF_ANALOG_GAIN, RST_ANALOG_GAIN);
        rdc(OFF_BYPASS_READ, RST_BYPASS_READ);
        rdc(OFF_SEQ_CTRL, RST_SEQ_CTRL);
        wr(OFF_READOUT_VALUE, 16'hFFFF);
        rdc(OFF_READOUT_VALUE, 16'h0000);
        rdc(16'h0469, 16'h0000);
        $display("test reset values done");
        for (k = 0; k < 6; k++) begin
            v = 16'($random(seed));
            wr(OFF_ANALOG_GAIN, v);
            rdc(OFF_ANALOG_GAIN, v);
            chk({dc_offset_trim_o, combined_gain_arith_o, second_stage_gain_o,
                first_stage_gain_o}, v);
            v = 16'($random(seed));
            wr(OFF_BYPASS_READ, v);
            rdc(OFF_BYPASS_READ, v);
            chk({7'h0, sensor_decimation_o, gain_cal_decimation_o,
                offset_cal_decimation_o}, {7'h0, v[11:3]});
            v = (16'($random(seed)) & 16'h01FF) | 16'h0004;
            wr(OFF_SEQ_CTRL, v | 16'hFE00);
            rdc(OFF_SEQ_CTRL, v & 16'h01FE);
        end
        $display("test register access done");
        wr(OFF_SEQ_CTRL, 16'h0001);
        cyc(30);
        rdc(OFF_SEQ_CTRL, 16'h0001);
        chk({15'h0, sensor_rst_o}, 16'h0001);
        link_up_i = 1'b1;
        finish_pass(16'h0000, 0, 0);
        cyc(200);
        chk({15'h0, sensor_rst_o}, 16'h0001);
        link_up_i = 1'b0;
        for (k = 1; k < 4; k++) begin
            dv = 2'(($random(seed) & 32'hFF) % 3);
            v = {8'h00, k[1], k[0], dv, 4'b1001};
            wr(OFF_SEQ_CTRL, v);
            finish_pass(v & 16'hFFFE, k / 2, k % 2);
        end
        wr(OFF_SEQ_CTRL, 16'h000B);
        wt(1, 3'h7);
        wt(1, 3'h0);
        cyc(3);
        chk({15'h0, sensor_rst_o}, 16'h0000);
        wr(OFF_SEQ_CTRL, 16'h0004);
        cyc(3);
        chk({14'h0, mon_rst_o, sensor_rst_o}, 16'h0003);
        rdc(OFF_SEQ_CTRL, 16'h0004);
        wr(OFF_SEQ_CTRL, 16'h0104);
        cyc(12);
        hist(0, 0, 1);
        $display("test sequencer done");
        seq_bypass_i = 1'b1;
        for (k = 0; k < 4; k++) begin
            v = 16'($random(seed)) & 16'h8007;
            wr(OFF_BYPASS_READ, v);
            cyc(3);
            chk({12'h0, sensor_rst_o, sensor_sel_o},
                {12'h0, v[15], v[2:0]});
        end
        seq_bypass_i = 1'b0;
        $display("test bypass done");
        print_verdict;
    end
endmodule
